// file: lrsc_top.sv
// Top of the radiation and stand-by controller with its APB register file
`timescale 1ns/10ps
`include "lrsc_cfg.svh"

module lrsc_top
	import lrsc_pkg::*;
#(
	parameter int unsigned P_TICK_CYCLES = `LRSC_TICK_CYCLES
) (
	// Clock, reset, enable
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	input  wire logic        i_ce,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Operator and PLC inputs
	input  wire logic [3:0]  i_plc_in,
	input  wire logic        i_foot,
	input  wire logic        i_start_btn,
	input  wire logic        i_standby_btn,
	input  wire logic [11:0] i_temp,
	// Unit outputs
	output logic [3:0]       o_led_drive,
	output logic             o_driver_en,
	output logic             o_display_en,
	output logic             o_standby_led,
	output logic             o_fault,
	output logic             o_irq
);

	localparam int NCH = 4;

	function automatic logic lrsc_any(input logic [3:0] mask, input logic [3:0] vec);
		lrsc_any = |(mask & vec);
	endfunction : lrsc_any

	function automatic logic lrsc_chan_hit(input logic [7:0] addr, input logic [3:0] idx);
		lrsc_chan_hit = (addr[7:4] == idx) & (addr[1:0] == 2'b00);
	endfunction : lrsc_chan_hit

	////////////////////////////////////////////////////////////////////////
	// Registers
	lrsc_chan_cfg_type   chan_cfg [NCH];
	lrsc_chan_stat_type  chan_stat [NCH];
	lrsc_sys_state_type  sys_state;
	lrsc_sys_state_type  next_sys_state;
	logic                pulse_mode;
	logic [9:0]          stby_time;
	logic [11:0]         temp_limit;
	logic                fault;
	logic [3:0]          irq_status;
	logic [3:0]          irq_mask;
	logic [20:0]         tick_cnt;
	logic                tick;
	logic [9:0]          idle_tick;
	logic [9:0]          idle_min;
	logic [9:0]          hour_tick;
	logic [5:0]          minutes;
	logic [15:0]         hours;
	logic [3:0]          plc_q;
	logic                foot_q;
	logic                start_q;
	logic                stby_q;

	////////////////////////////////////////////////////////////////////////
	// Input edges; inputs are already synchronous to the clock
	wire [3:0] plc_rise   = i_plc_in & ~plc_q;
	wire       foot_rise  = i_foot & !foot_q;
	wire       start_rise = i_start_btn & !start_q;
	wire       stby_rise  = i_standby_btn & !stby_q;
	wire       plc_change = (i_plc_in != plc_q);
	wire       key_evt    = foot_rise | start_rise | stby_rise;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			plc_q   <= 4'h0;
			foot_q  <= 1'b0;
			start_q <= 1'b0;
			stby_q  <= 1'b0;
		end else if (i_ce) begin
			plc_q   <= i_plc_in;
			foot_q  <= i_foot;
			start_q <= i_start_btn;
			stby_q  <= i_standby_btn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 0.1 s time base, free running so delays and timeouts share one grid
	wire tick_wrap = (tick_cnt == 21'(P_TICK_CYCLES - 1));

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			tick_cnt <= 21'h00_0000;
			tick     <= 1'b0;
		end else if (i_ce) begin
			tick_cnt <= tick_wrap ? 21'h00_0000 : tick_cnt + 21'h00_0001;
			tick     <= tick_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channels
	wire kill = (sys_state == SYS_STANDBY) | fault;
	logic [3:0] led_on;
	logic [3:0] led_busy;
	logic [3:0] led_done;

	generate
		for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
			wire press = (start_rise & chan_cfg[ch].panel_en) | (foot_rise & chan_cfg[ch].foot_en);
			wire plc_l = lrsc_any(chan_cfg[ch].plc_mask, i_plc_in);
			wire plc_r = lrsc_any(chan_cfg[ch].plc_mask, plc_rise);

			lrsc_chan u_chan (
				.i_clock      (i_clock),
				.i_srst       (i_srst),
				.i_ce         (i_ce),
				.i_tick       (tick),
				.i_press      (press),
				.i_plc_level  (plc_l),
				.i_plc_rise   (plc_r),
				.i_pulse_mode (pulse_mode),
				.i_kill       (kill),
				.i_cfg        (chan_cfg[ch]),
				.o_stat       (chan_stat[ch])
			);

			assign led_on[ch]   = chan_stat[ch].on;
			assign led_busy[ch] = chan_stat[ch].on | chan_stat[ch].delaying;
			assign led_done[ch] = chan_stat[ch].done;
		end
	endgenerate

	wire any_busy = |led_busy;

	////////////////////////////////////////////////////////////////////////
	// Stand-by inactivity timer in minutes
	wire idle_reset = key_evt | plc_change | any_busy;
	wire idle_min_step = tick & (idle_tick == `LRSC_TICKS_PER_MIN - 10'h001);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			idle_tick <= 10'h000;
			idle_min  <= 10'h000;
		end else if (i_ce) begin
			if (idle_reset || sys_state == SYS_STANDBY) begin
				idle_tick <= 10'h000;
				idle_min  <= 10'h000;
			end else if (tick) begin
				idle_tick <= idle_min_step ? 10'h000 : idle_tick + 10'h001;
				if (idle_min_step && idle_min != `LRSC_STBY_MAX) begin
					idle_min <= idle_min + 10'h001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stand-by state
	wire quiet      = !any_busy & (i_plc_in == 4'h0);
	wire auto_stby  = (stby_time != 10'h000) & (idle_min >= stby_time) & !any_busy;
	wire stby_enter = (sys_state == SYS_RUN) & (next_sys_state == SYS_STANDBY);
	wire stby_wake  = (sys_state == SYS_STANDBY) & (next_sys_state == SYS_RUN);

	always_comb begin
		next_sys_state = sys_state;
		unique case (sys_state)
			SYS_RUN: begin
				if ((stby_rise & quiet) | auto_stby) begin
					next_sys_state = SYS_STANDBY;
				end
			end
			SYS_STANDBY: begin
				if (stby_rise | (|plc_rise)) begin
					next_sys_state = SYS_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			sys_state <= SYS_RUN;
		end else if (i_ce) begin
			sys_state <= next_sys_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unit operating hours; stop while in stand-by or shut down
	wire ready = (sys_state == SYS_RUN) & !fault;
	wire hour_min_step = ready & tick & (hour_tick == `LRSC_TICKS_PER_MIN - 10'h001);
	wire min_wrap = (minutes == `LRSC_MIN_PER_HOUR - 6'h01);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			hour_tick <= 10'h000;
			minutes   <= 6'h00;
			hours     <= 16'h0000;
		end else if (i_ce && ready && tick) begin
			hour_tick <= hour_min_step ? 10'h000 : hour_tick + 10'h001;
			if (hour_min_step) begin
				minutes <= min_wrap ? 6'h00 : minutes + 6'h01;
				if (min_wrap) begin
					hours <= hours + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode
	wire        wr_en    = i_psel & i_penable & i_pwrite;
	wire        setup    = i_psel & !i_penable;
	wire [2:0]  ch_idx   = 3'(i_paddr[7:4] - `LRSC_OFS_CHAN_BASE);
	wire [1:0]  ch_sub   = i_paddr[3:2];
	wire        ch_range = (i_paddr[7:4] >= `LRSC_OFS_CHAN_BASE) & (i_paddr[7:4] <= 4'h4) & (i_paddr[1:0] == 2'b00);
	wire        ch_hit   = ch_range & (ch_sub != 2'h3);
	wire        glb_hit  = (i_paddr == `LRSC_OFS_CTRL) | (i_paddr == `LRSC_OFS_STBY_TIME)
		| (i_paddr == `LRSC_OFS_TEMP_LIMIT) | (i_paddr == `LRSC_OFS_STATUS) | (i_paddr == `LRSC_OFS_HOURS)
		| (i_paddr == `LRSC_OFS_IRQ_STATUS) | (i_paddr == `LRSC_OFS_IRQ_MASK);
	wire        hit      = ch_hit | glb_hit;

	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & !hit;

	wire wr_ctrl  = wr_en & (i_paddr == `LRSC_OFS_CTRL);
	wire wr_stby  = wr_en & (i_paddr == `LRSC_OFS_STBY_TIME);
	wire wr_limit = wr_en & (i_paddr == `LRSC_OFS_TEMP_LIMIT);
	wire wr_istat = wr_en & (i_paddr == `LRSC_OFS_IRQ_STATUS);
	wire wr_imask = wr_en & (i_paddr == `LRSC_OFS_IRQ_MASK);

	// Times of 1000 to 1023 minutes in bits 9:0 are clipped to 999; higher write bits are dropped
	wire [9:0] stby_wdata = (i_pwdata[9:0] > `LRSC_STBY_MAX) ? `LRSC_STBY_MAX : i_pwdata[9:0];

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pulse_mode <= 1'b0;
			stby_time  <= `LRSC_RST_STBY_TIME;
			temp_limit <= `LRSC_RST_TEMP_LIMIT;
			irq_mask   <= 4'h0;
		end else if (i_ce) begin
			if (wr_ctrl) begin
				pulse_mode <= i_pwdata[`LRSC_CTRL_PULSE];
			end
			if (wr_stby) begin
				stby_time <= stby_wdata;
			end
			if (wr_limit) begin
				temp_limit <= i_pwdata[11:0];
			end
			if (wr_imask) begin
				irq_mask <= i_pwdata[3:0];
			end
		end
	end

	generate
		for (genvar ch = 0; ch < NCH; ch++) begin : g_chan_reg
			wire hit_c = wr_en & lrsc_chan_hit(i_paddr, 4'(ch + 1));
			// Settings are frozen while any channel runs so a cycle never sees them change
			wire wr_ok = hit_c & !any_busy;

			always_ff @(posedge i_clock) begin
				if (i_srst) begin
					chan_cfg[ch] <= '{rad_time: `LRSC_RST_RAD_TIME, delay: `LRSC_RST_DELAY,
						foot_en: 1'b0, panel_en: 1'b0, plc_mask: 4'h0};
				end else if (i_ce && wr_ok) begin
					if (ch_sub == `LRSC_SUB_RAD_TIME) begin
						chan_cfg[ch].rad_time <= i_pwdata[15:0];
					end
					if (ch_sub == `LRSC_SUB_DELAY) begin
						chan_cfg[ch].delay <= i_pwdata[15:0];
					end
					if (ch_sub == `LRSC_SUB_SOURCE) begin
						chan_cfg[ch].plc_mask <= i_pwdata[3:0];
						chan_cfg[ch].panel_en <= i_pwdata[`LRSC_SRC_PANEL];
						chan_cfg[ch].foot_en  <= i_pwdata[`LRSC_SRC_FOOT];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Overtemperature; the fault stays until cleared with the limit met
	wire over_temp = (i_temp > temp_limit);
	wire fault_clr = wr_ctrl & i_pwdata[`LRSC_CTRL_FAULT_CLR];

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			fault <= 1'b0;
		end else if (i_ce) begin
			if (over_temp) begin
				fault <= 1'b1;
			end else if (fault_clr) begin
				fault <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over the write-one clear
	wire [3:0] irq_evt;
	assign irq_evt[`LRSC_IRQ_STBY]     = stby_enter;
	assign irq_evt[`LRSC_IRQ_WAKE]     = stby_wake;
	assign irq_evt[`LRSC_IRQ_OVERTEMP] = over_temp & !fault;
	assign irq_evt[`LRSC_IRQ_DONE]     = |led_done;

	wire [3:0] irq_clr = wr_istat ? i_pwdata[3:0] : 4'h0;

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			irq_status <= 4'h0;
			o_irq      <= 1'b0;
		end else if (i_ce) begin
			irq_status <= (irq_status & ~irq_clr) | irq_evt;
			o_irq      <= |(((irq_status & ~irq_clr) | irq_evt) & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup cycle
	logic [31:0] ch_rdata;
	logic [31:0] rdata;

	always_comb begin
		ch_rdata = 32'h0000_0000;
		if (ch_range && ch_idx < 3'(NCH)) begin
			unique case (ch_sub)
				`LRSC_SUB_RAD_TIME: ch_rdata = {16'h0000, chan_cfg[ch_idx[1:0]].rad_time};
				`LRSC_SUB_DELAY:    ch_rdata = {16'h0000, chan_cfg[ch_idx[1:0]].delay};
				`LRSC_SUB_SOURCE:   ch_rdata = {26'h000_0000, chan_cfg[ch_idx[1:0]].foot_en,
					chan_cfg[ch_idx[1:0]].panel_en, chan_cfg[ch_idx[1:0]].plc_mask};
				default:            ch_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		unique case (i_paddr)
			`LRSC_OFS_CTRL:       rdata = {31'h0000_0000, pulse_mode};
			`LRSC_OFS_STBY_TIME:  rdata = {22'h00_0000, stby_time};
			`LRSC_OFS_TEMP_LIMIT: rdata = {20'h0_0000, temp_limit};
			`LRSC_OFS_STATUS:     rdata = {22'h00_0000, fault, sys_state == SYS_STANDBY, led_busy & ~led_on, led_on};
			`LRSC_OFS_HOURS:      rdata = {8'h00, hours, 2'b00, minutes};
			`LRSC_OFS_IRQ_STATUS: rdata = {28'h000_0000, irq_status};
			`LRSC_OFS_IRQ_MASK:   rdata = {28'h000_0000, irq_mask};
			default:              rdata = ch_rdata;
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_prdata <= 32'h0000_0000;
		end else if (i_ce && setup) begin
			o_prdata <= rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unit outputs
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_led_drive   <= 4'h0;
			o_driver_en   <= 1'b1;
			o_display_en  <= 1'b1;
			o_standby_led <= 1'b0;
			o_fault       <= 1'b0;
		end else if (i_ce) begin
			o_led_drive   <= kill ? 4'h0 : led_on;
			o_driver_en   <= !kill;
			o_display_en  <= !kill;
			o_standby_led <= (sys_state == SYS_STANDBY);
			o_fault       <= fault;
		end
	end

endmodule : lrsc_top

// file: lrsc_cfg.svh
// Offsets, field positions, reset values and timing counts of the radiation and stand-by controller
`ifndef LRSC_CFG_SVH
`define LRSC_CFG_SVH

// Timing
`define LRSC_CLOCK_PERIOD_NS 50
`define LRSC_TICK_TIME_NS    100000000
`define LRSC_TICK_CYCLES     (`LRSC_TICK_TIME_NS / `LRSC_CLOCK_PERIOD_NS)
`define LRSC_TICKS_PER_MIN   10'h0258
`define LRSC_MIN_PER_HOUR    6'h3C
`define LRSC_STBY_MAX        10'h03E7

// Register byte offsets; the channel base is the value of address bits 7:4
`define LRSC_OFS_CTRL        8'h00
`define LRSC_OFS_STBY_TIME   8'h04
`define LRSC_OFS_TEMP_LIMIT  8'h08
`define LRSC_OFS_CHAN_BASE   4'h1
`define LRSC_OFS_STATUS      8'h50
`define LRSC_OFS_HOURS       8'h54
`define LRSC_OFS_IRQ_STATUS  8'h58
`define LRSC_OFS_IRQ_MASK    8'h5C

// Channel sub-register word index
`define LRSC_SUB_RAD_TIME    2'h0
`define LRSC_SUB_DELAY       2'h1
`define LRSC_SUB_SOURCE      2'h2

// Field positions
`define LRSC_CTRL_PULSE      0
`define LRSC_CTRL_FAULT_CLR  1
`define LRSC_SRC_PANEL       4
`define LRSC_SRC_FOOT        5
`define LRSC_IRQ_STBY        0
`define LRSC_IRQ_WAKE        1
`define LRSC_IRQ_OVERTEMP    2
`define LRSC_IRQ_DONE        3

// Reset values
`define LRSC_RST_RAD_TIME    16'h001E
`define LRSC_RST_DELAY       16'h0000
`define LRSC_RST_STBY_TIME   10'h000
`define LRSC_RST_TEMP_LIMIT  12'h0258

`endif

// file: lrsc_pkg.sv
// Types shared by the radiation and stand-by controller
package lrsc_pkg;

	typedef enum logic [1:0] {
		CH_IDLE  = 2'b00,
		CH_DELAY = 2'b01,
		CH_ON    = 2'b10
	} lrsc_chan_state_type;

	typedef enum logic {
		SYS_RUN     = 1'b0,
		SYS_STANDBY = 1'b1
	} lrsc_sys_state_type;

	typedef struct packed {
		logic [15:0] rad_time;
		logic [15:0] delay;
		logic        foot_en;
		logic        panel_en;
		logic [3:0]  plc_mask;
	} lrsc_chan_cfg_type;

	typedef struct packed {
		logic on;
		logic delaying;
		logic done;
	} lrsc_chan_stat_type;

endpackage : lrsc_pkg

// file: lrsc_chan.sv
// One LED channel: start delay, timed or continuous radiation, stop handling
`timescale 1ns/10ps
module lrsc_chan
	import lrsc_pkg::*;
(
	// Clock and reset
	input  wire logic               i_clock,
	input  wire logic               i_srst,
	input  wire logic               i_ce,
	// Time base and requests, already gated by source enables
	input  wire logic               i_tick,
	input  wire logic               i_press,
	input  wire logic               i_plc_level,
	input  wire logic               i_plc_rise,
	input  wire logic               i_pulse_mode,
	input  wire logic               i_kill,
	input  wire lrsc_chan_cfg_type  i_cfg,
	// Status
	output lrsc_chan_stat_type      o_stat
);

	lrsc_chan_state_type state;
	lrsc_chan_state_type next_state;
	logic [15:0]         cnt;
	logic [15:0]         next_cnt;
	logic                by_plc;
	logic                next_by_plc;
	logic                next_done;

	////////////////////////////////////////////////////////////////////////
	wire continuous = (i_cfg.rad_time == 16'h0000);
	wire plc_start  = i_plc_rise | (!i_pulse_mode & continuous & i_plc_level);
	wire go         = i_press | plc_start;
	wire delay_done = (cnt >= i_cfg.delay);
	wire time_done  = !continuous & (cnt >= i_cfg.rad_time);
	// Standard mode only drops on level loss when the level started it
	wire plc_stop   = continuous & (i_pulse_mode ? i_plc_rise : (by_plc & !i_plc_level));
	wire stop       = i_press | time_done | plc_stop;

	always_comb begin
		next_state  = state;
		next_cnt    = i_tick ? cnt + 16'h0001 : cnt;
		next_by_plc = by_plc;
		next_done   = 1'b0;
		unique case (state)
			CH_IDLE: begin
				next_cnt = 16'h0000;
				if (go) begin
					next_state  = CH_DELAY;
					next_by_plc = !i_press;
				end
			end
			CH_DELAY: begin
				if (i_press) begin
					next_state = CH_IDLE;
				end else if (delay_done) begin
					next_state = CH_ON;
					next_cnt   = 16'h0000;
				end
			end
			CH_ON: begin
				if (stop) begin
					next_state = CH_IDLE;
					next_done  = time_done;
				end
			end
			default: begin
				next_state = CH_IDLE;
			end
		endcase
		if (i_kill) begin
			next_state = CH_IDLE;
			next_done  = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state  <= CH_IDLE;
			cnt    <= 16'h0000;
			by_plc <= 1'b0;
			o_stat <= '0;
		end else if (i_ce) begin
			state  <= next_state;
			cnt    <= next_cnt;
			by_plc <= next_by_plc;
			o_stat <= '{on: next_state == CH_ON, delaying: next_state == CH_DELAY, done: next_done};
		end
	end

endmodule : lrsc_chan

// file: lrsc_top_sva.sv
// Port assertions for the radiation and stand-by controller
`timescale 1ns/10ps
module lrsc_top_sva #(
	parameter int unsigned P_TICK_CYCLES = 4
) (
	// Clock and reset
	input wire logic        i_clock,
	input wire logic        i_srst,
	// APB
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [7:0]  i_paddr,
	input wire logic        o_pslverr,
	// Unit
	input wire logic [3:0]  i_plc_in,
	input wire logic        i_standby_btn,
	input wire logic [11:0] i_temp,
	input wire logic [3:0]  o_led_drive,
	input wire logic        o_driver_en,
	input wire logic        o_display_en,
	input wire logic        o_standby_led,
	input wire logic        o_fault,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);

	////////////////////////////////////////
	sequence s_key;
		$rose(i_standby_btn);
	endsequence
	sequence s_plc_edge;
		(i_plc_in & ~$past(i_plc_in)) != 4'h0;
	endsequence

	// Reset must clear the LED drive, stand-by LED, fault and irq outputs even though the other checks are off during it
	property p_reset_clear;
		disable iff (1'b0) i_srst |=> o_led_drive == 4'h0 && !o_standby_led && !o_fault && !o_irq;
	endproperty
	property p_slverr;
		i_psel && i_penable && i_paddr inside {8'h0C, 8'h1C, 8'h60} |-> o_pslverr;
	endproperty
	property p_stby_dark;
		o_standby_led |-> !o_display_en && !o_driver_en && o_led_drive == 4'h0;
	endproperty
	property p_fault_off;
		o_fault && $past(o_fault, 2) |-> o_led_drive == 4'h0 && !o_driver_en && !o_display_en;
	endproperty
	property p_overtemp;
		i_temp > 12'h0258 |-> ##[1:3] o_fault;
	endproperty
	property p_wake_key;
		o_standby_led ##0 s_key |-> ##[1:4] !o_standby_led;
	endproperty
	property p_wake_plc;
		o_standby_led ##0 s_plc_edge |-> ##[1:4] !o_standby_led;
	endproperty
	property p_key_busy;
		!o_standby_led && (o_led_drive != 4'h0 || i_plc_in != 4'h0) ##0 s_key |=> !o_standby_led [*4];
	endproperty

	a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
	a_slverr: assert property (p_slverr) else $error("unmapped access without error");
	a_stby_dark: assert property (p_stby_dark) else $error("stand-by with display or driver on");
	a_fault_off: assert property (p_fault_off) else $error("fault with outputs on");
	a_overtemp: assert property (p_overtemp) else $error("over temperature not flagged");
	a_wake_key: assert property (p_wake_key) else $error("key did not wake unit");
	a_wake_plc: assert property (p_wake_plc) else $error("input edge did not wake unit");
	a_key_busy: assert property (p_key_busy) else $error("stand-by entered while busy");
endmodule : lrsc_top_sva

bind lrsc_top lrsc_top_sva #(.P_TICK_CYCLES(P_TICK_CYCLES)) sva_u (.i_clock, .i_srst, .i_psel, .i_penable,
	.i_paddr, .o_pslverr, .i_plc_in, .i_standby_btn, .i_temp, .o_led_drive, .o_driver_en, .o_display_en,
	.o_standby_led, .o_fault, .o_irq);

// file: lrsc_operator_model.sv
// Stand-in for the PLC, the foot switch and the front keys
`timescale 1ns/10ps
module lrsc_operator_model (
	// Clock
	input  wire logic i_clock,
	// Lines into the unit
	output logic [3:0] o_plc_in,
	output logic       o_foot,
	output logic       o_start_btn,
	output logic       o_standby_btn
);
	initial begin
		o_plc_in = 4'h0;
		o_foot = 1'b0;
		o_start_btn = 1'b0;
		o_standby_btn = 1'b0;
	end

	// Key 1 foot, 2 start, 3 stand-by; a long hold stands for a slow operator
	task press(input int k, input int hold);
		@(posedge i_clock);
		o_foot <= (k == 1);
		o_start_btn <= (k == 2);
		o_standby_btn <= (k == 3);
		repeat (hold) @(posedge i_clock);
		o_foot <= 1'b0;
		o_start_btn <= 1'b0;
		o_standby_btn <= 1'b0;
		@(posedge i_clock);
	endtask : press

	// Levels held two cycles so a pulse is never shorter than a sample
	task plc(input logic [3:0] v);
		@(posedge i_clock);
		o_plc_in <= v;
		repeat (2) @(posedge i_clock);
	endtask : plc
endmodule : lrsc_operator_model

// file: tb_top.sv
// Self-checking bench for the radiation and stand-by controller
`timescale 1ns/10ps
module tb_top;
	logic        i_clock;
	logic        i_srst;
	logic        i_ce;
	logic        i_psel;
	logic        i_penable;
	logic        i_pwrite;
	logic [7:0]  i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic [3:0]  i_plc_in;
	logic        i_foot;
	logic        i_start_btn;
	logic        i_standby_btn;
	logic [11:0] i_temp;
	logic [3:0]  o_led_drive;
	logic        o_driver_en;
	logic        o_display_en;
	logic        o_standby_led;
	logic        o_fault;
	logic        o_irq;
	int          mismatches;
	int          n_compared;
	int          n;
	logic [31:0] r;
	logic        e;
	logic [31:0] h0;

	lrsc_top #(.P_TICK_CYCLES(4)) dut_u (.i_clock, .i_srst, .i_ce, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_plc_in, .i_foot, .i_start_btn,
		.i_standby_btn, .i_temp, .o_led_drive, .o_driver_en, .o_display_en, .o_standby_led, .o_fault, .o_irq);
	lrsc_operator_model op_u (.i_clock, .o_plc_in(i_plc_in), .o_foot(i_foot), .o_start_btn(i_start_btn),
		.o_standby_btn(i_standby_btn));

	initial begin
		i_clock = 1'b0;
		forever #25 i_clock = ~i_clock;
	end

	////////////////////////////////////////
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	task hang;
		mismatches++;
		$display("ERROR %0t: wait ran out", $time);
		test_done();
	endtask : hang

	task chk(input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, s, x);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clock);
			k++;
		end while (o_pready !== 1'b1 && k < 20);
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (o_pready !== 1'b1) hang();
	endtask : apb

	task rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, x);
	endtask : rdc

	// Waits for {stand-by, LEDs} under a mask; n gives the cycles taken
	task wst(input logic [4:0] m, input logic [4:0] v, input int lim);
		n = 0;
		do begin
			@(negedge i_clock);
			n++;
		end while (({o_standby_led, o_led_drive} & m) !== v && n < lim);
		if (({o_standby_led, o_led_drive} & m) !== v) hang();
	endtask : wst

	////////////////////////////////////////
	initial begin
		mismatches = 0;
		n_compared = 0;
		i_srst = 1'b1;
		i_ce = 1'b1;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 8'h00;
		i_pwdata = 32'h0000_0000;
		i_temp = 12'h0190;
		repeat (12) @(posedge i_clock);
		i_srst <= 1'b0;
		rdc(8'h04, 32'h0000_0000);
		rdc(8'h08, 32'h0000_0258);
		rdc(8'h10, 32'h0000_001E);
		rdc(8'h0C, 32'h0000_0000);
		chk(e, 1'b1);
		// Ch1 timed by foot, ch2 continuous delayed by key, ch3 continuous on PLC input 1
		apb(1'b1, 8'h10, 32'h0000_0008);
		apb(1'b1, 8'h18, 32'h0000_0020);
		apb(1'b1, 8'h20, 32'h0000_0000);
		apb(1'b1, 8'h24, 32'h0000_0003);
		apb(1'b1, 8'h28, 32'h0000_0010);
		apb(1'b1, 8'h30, 32'h0000_0000);
		apb(1'b1, 8'h38, 32'h0000_0001);
		apb(1'b1, 8'h5C, 32'h0000_0008);
		op_u.press(1, 2);
		wst(5'h01, 5'h01, 40);
		chk(o_led_drive, 4'h1);
		wst(5'h01, 5'h00, 50);
		chk(n >= 26 && n <= 40, 1'b1);
		rdc(8'h58, 32'h0000_0008);
		@(negedge i_clock);
		chk(o_irq, 1'b1);
		apb(1'b1, 8'h58, 32'h0000_000F);
		repeat (3) @(negedge i_clock);
		chk(o_irq, 1'b0);
		op_u.press(1, 2);
		wst(5'h01, 5'h01, 40);
		op_u.press(1, 3);
		wst(5'h01, 5'h00, 8);
		op_u.press(2, 2);
		rdc(8'h50, 32'h0000_0020);
		wst(5'h02, 5'h02, 40);
		repeat (200) @(negedge i_clock);
		chk(o_led_drive, 4'h2);
		op_u.press(2, 2);
		wst(5'h02, 5'h00, 10);
		op_u.plc(4'h1);
		wst(5'h04, 5'h04, 10);
		repeat (100) @(negedge i_clock);
		chk(o_led_drive, 4'h4);
		op_u.plc(4'h0);
		wst(5'h04, 5'h00, 10);
		apb(1'b1, 8'h00, 32'h0000_0001);
		op_u.plc(4'h1);
		op_u.plc(4'h0);
		wst(5'h04, 5'h04, 10);
		repeat (50) @(negedge i_clock);
		chk(o_led_drive, 4'h4);
		op_u.plc(4'h1);
		op_u.plc(4'h0);
		wst(5'h04, 5'h00, 10);
		apb(1'b1, 8'h00, 32'h0000_0000);
		////////////////////////////////////////
		apb(1'b1, 8'h58, 32'h0000_000F);
		op_u.plc(4'h2);
		op_u.press(3, 2);
		repeat (6) @(negedge i_clock);
		chk(o_standby_led, 1'b0);
		op_u.plc(4'h0);
		apb(1'b0, 8'h54, 32'h0000_0000);
		h0 = r;
		// Exactly one minute of ticks between the two captures
		repeat (2397) @(posedge i_clock);
		rdc(8'h54, {h0[31:6], h0[5:0] + 6'h01});
		op_u.press(3, 2);
		wst(5'h10, 5'h10, 10);
		chk({o_display_en, o_driver_en, o_irq}, 3'b000);
		rdc(8'h58, 32'h0000_0001);
		apb(1'b0, 8'h54, 32'h0000_0000);
		h0 = r;
		repeat (2397) @(posedge i_clock);
		rdc(8'h54, h0);
		op_u.press(3, 2);
		wst(5'h10, 5'h00, 10);
		op_u.press(3, 2);
		wst(5'h10, 5'h10, 10);
		op_u.plc(4'h2);
		wst(5'h10, 5'h00, 10);
		op_u.plc(4'h0);
		chk(o_led_drive, 4'h0);
		apb(1'b1, 8'h04, 32'h0000_0002);
		repeat (2300) @(negedge i_clock);
		chk(o_standby_led, 1'b0);
		// Input activity restarts the idle count, so the first deadline passes quietly
		op_u.plc(4'h2);
		op_u.plc(4'h0);
		repeat (2700) @(negedge i_clock);
		chk(o_standby_led, 1'b0);
		wst(5'h10, 5'h10, 2300);
		op_u.press(3, 2);
		wst(5'h10, 5'h00, 10);
		apb(1'b1, 8'h04, 32'h0000_03E8);
		rdc(8'h04, 32'h0000_03E7);
		apb(1'b1, 8'h04, 32'h0000_0000);
		////////////////////////////////////////
		op_u.press(2, 2);
		wst(5'h02, 5'h02, 40);
		@(posedge i_clock);
		i_temp <= 12'h0259;
		repeat (6) @(negedge i_clock);
		chk({o_fault, o_led_drive, o_driver_en, o_display_en}, 7'b1_0000_00);
		rdc(8'h50, 32'h0000_0200);
		rdc(8'h58, 32'h0000_0007);
		@(posedge i_clock);
		i_temp <= 12'h0190;
		apb(1'b1, 8'h00, 32'h0000_0002);
		repeat (2) @(negedge i_clock);
		chk(o_fault, 1'b0);
		// Frozen unit: a stand-by key edge and a register write both go unseen
		@(posedge i_clock);
		i_ce <= 1'b0;
		op_u.press(3, 2);
		apb(1'b1, 8'h04, 32'h0000_0005);
		@(posedge i_clock);
		i_ce <= 1'b1;
		rdc(8'h04, 32'h0000_0000);
		chk(o_standby_led, 1'b0);
		test_done();
	end
endmodule : tb_top
